// *** simsc_pkg.sv ***
// Shared constants and types for the card slot control register bank
package simsc_pkg;
  // Register offsets
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SLOT_CTRL = 8'h08;
  localparam logic [7:0] OFS_BAT_DBC = 8'h0a;
  localparam logic [7:0] OFS_SDN_DBC = 8'h0b;
  localparam logic [7:0] OFS_CLK_SRC = 8'h0d;
  // Values after reset
  localparam logic [7:0] RST_SLOT_CTRL = 8'h00;
  localparam logic [7:0] RST_DBC = 8'h04;
  localparam logic [7:0] RST_CLK_SRC = 8'h00;
  // Slot control field positions
  localparam int SLOT1_REG_EN = 0;
  localparam int SLOT1_VSEL = 1;
  localparam int SLOT1_STATE_LO = 2;
  localparam int SLOT2_REG_EN = 4;
  localparam int SLOT2_VSEL = 5;
  localparam int SLOT2_STATE_LO = 6;
  // Status register field positions
  localparam int ST_SDN_LEVEL = 0;
  localparam int ST_SDN_FLAG = 1;
  localparam int ST_BAT_LEVEL = 2;
  localparam int ST_BAT_FLAG = 3;
  localparam int ST_SLOT1_LO = 4;
  localparam int ST_SLOT2_LO = 6;
  // Clock source select bit
  localparam int CLK_SRC_BIT = 7;
  // Slot state and status codes
  localparam logic [1:0] CODE_DOWN = 2'h0;
  localparam logic [1:0] CODE_ISOL = 2'h1;
  localparam logic [1:0] CODE_PWR_PD = 2'h2;
  localparam logic [1:0] CODE_ACTIVE = 2'h3;
  // Serial target address, low bit from the interrupt pin at reset
  localparam logic [5:0] TGT_ADDR_HI = 6'h1e;
  // Timing clock derived from the system clock
  localparam int CLK_HZ = 20_000_000;
  localparam int TIMING_HZ = 32_768;
  localparam logic [9:0] TICK_DIV = 10'(CLK_HZ / TIMING_HZ);
  // Serial target states
  typedef enum logic [2:0] {
    SER_IDLE, SER_ADDR, SER_PTR, SER_WDATA, SER_ACK, SER_TX, SER_TX_ACK
  } simsc_ser_t;
  // Per-slot drive to the regulator and the level translator
  typedef struct packed {
    logic supply_on;
    logic supply_pulldown;
    logic volt_high;
    logic iface_pulldown;
    logic iface_active;
    logic [1:0] status;
  } simsc_slot_t;
endpackage

// *** simsc_regs.sv ***
// Card slot control register bank with serial target and debouncers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Regulator bit on turns regulator on; off turns it off with pull-down.
// - Voltage select bit picks 1.8 V at 0, 2.95 V at 1.
// - Two-bit slot state: 00 down, 01 isolated, 11 active, 10 banned.
// - Code 10 is stored as written; software must never write it.
// - State field and regulator bit are stored independently.
// - Slot status codes derive from state and regulator bits.
// - Regulator off always reports status 00.
// - Status 01 only with state 01 and regulator on.
// - Status 11 only with state 11 and regulator on.
// - Regulator on with state 00 or 10 reports status 10.
// - Battery debounce register is reload value; zero bypasses.
// - Shutdown debounce register is reload value; zero bypasses.
// - Writing a debounce register restarts its counter.
// - New debounce value acts within one timing clock period.
// - Clock source bit 7 picks internal or external timing clock.
// - Reset loads defaults: debounce 04h, regulators off, flags clear.
// - Shutdown level captured into status when its flag is set.
// - Serial target address low bit is interrupt pin level at reset.
module simsc_regs
  import simsc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_irq_pin,
  input wire logic i_ext_timing_clk,
  input wire logic i_shutdown_input,
  input wire logic i_battery_presence_input,
  output simsc_slot_t o_slot_one_supply,
  output simsc_slot_t o_slot_two_supply
);
  // Register storage
  logic [7:0] slot_ctrl_ff, nxt_slot_ctrl;
  logic [7:0] dbc_ff [2];
  logic [7:0] nxt_dbc [2];
  logic [7:0] clk_src_ff, nxt_clk_src;
  logic sdn_level_ff, nxt_sdn_level;
  logic sdn_flag_ff, nxt_sdn_flag;
  logic bat_flag_ff, nxt_bat_flag;
  // Serial target state
  simsc_ser_t ser_ff, nxt_ser, ret_ff, nxt_ret;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [3:0] bits_ff, nxt_bits;
  logic sda_oe_ff, nxt_sda_oe;
  logic scl_q_ff, sda_q_ff;
  logic addr_lsb_ff, nxt_addr_lsb;
  logic strap_done_ff;
  logic ack_ok_ff, nxt_ack_ok;
  logic wr_stb, rd_clr;
  logic [7:0] wr_data, rd_data, status_byte;
  // Timing clock and debouncers
  logic [9:0] div_ff, nxt_div;
  logic ext_q_ff;
  logic tick;
  logic [1:0] din, expire, restart;
  logic [1:0] level_ff, nxt_level;
  logic [7:0] cnt_ff [2];
  logic [7:0] nxt_cnt [2];
  simsc_slot_t nxt_one, nxt_two;

  // Status code of one slot from its state field and regulator bit
  function automatic logic [1:0] slot_status(input logic [1:0] st,
                                             input logic reg_on);
    logic [1:0] code;
    code = CODE_DOWN;
    if (reg_on) begin
      // Banned code 10 falls in with 00: powered, pull-downs kept
      code = (st == CODE_ISOL || st == CODE_ACTIVE) ? st : CODE_PWR_PD;
    end
    return code;
  endfunction

  // Bus line edges; pins count as synchronous to the reference clock
  wire scl_rise = i_scl & ~scl_q_ff;
  wire scl_fall = ~i_scl & scl_q_ff;
  wire bus_start = scl_q_ff & i_scl & sda_q_ff & ~i_sda;
  wire bus_stop = scl_q_ff & i_scl & ~sda_q_ff & i_sda;

  // Status byte and read mux
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_SDN_LEVEL] = sdn_level_ff;
    status_byte[ST_SDN_FLAG] = sdn_flag_ff;
    status_byte[ST_BAT_LEVEL] = level_ff[1];
    status_byte[ST_BAT_FLAG] = bat_flag_ff;
    status_byte[ST_SLOT1_LO +: 2] = slot_status(
      slot_ctrl_ff[SLOT1_STATE_LO +: 2], slot_ctrl_ff[SLOT1_REG_EN]);
    status_byte[ST_SLOT2_LO +: 2] = slot_status(
      slot_ctrl_ff[SLOT2_STATE_LO +: 2], slot_ctrl_ff[SLOT2_REG_EN]);
    case (ptr_ff)
      OFS_STATUS: rd_data = status_byte;
      OFS_SLOT_CTRL: rd_data = slot_ctrl_ff;
      OFS_BAT_DBC: rd_data = dbc_ff[1];
      OFS_SDN_DBC: rd_data = dbc_ff[0];
      OFS_CLK_SRC: rd_data = clk_src_ff;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial target: address, pointer, write bytes, read bytes
  always_comb begin
    nxt_ser = ser_ff;
    nxt_ret = ret_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_bits = bits_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_ack_ok = ack_ok_ff;
    wr_stb = 1'b0;
    wr_data = shift_ff;
    rd_clr = 1'b0;
    if (bus_stop) begin
      nxt_ser = SER_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (bus_start) begin
      nxt_ser = SER_ADDR;
      nxt_bits = 4'h0;
      nxt_sda_oe = 1'b0;
    end else begin
      case (ser_ff)
        SER_ADDR, SER_PTR, SER_WDATA: begin
          if (scl_rise && bits_ff != 4'h8) begin
            nxt_shift = {shift_ff[6:0], i_sda};
            nxt_bits = bits_ff + 4'h1;
          end else if (scl_fall && bits_ff == 4'h8) begin
            nxt_bits = 4'h0;
            nxt_ser = SER_ACK;
            nxt_sda_oe = 1'b1;
            nxt_ret = SER_WDATA;
            if (ser_ff == SER_ADDR) begin
              // Only our own address is acknowledged
              if (shift_ff[7:1] != {TGT_ADDR_HI, addr_lsb_ff}) begin
                nxt_ser = SER_IDLE;
                nxt_sda_oe = 1'b0;
              end
              nxt_ret = shift_ff[0] ? SER_TX : SER_PTR;
            end else if (ser_ff == SER_PTR) begin
              nxt_ptr = shift_ff;
            end else begin
              wr_stb = 1'b1;
              nxt_ptr = ptr_ff + 8'h1;
            end
          end
        end
        SER_ACK: begin
          if (scl_fall) begin
            nxt_ser = ret_ff;
            nxt_sda_oe = 1'b0;
            if (ret_ff == SER_TX) begin
              nxt_shift = rd_data;
              nxt_sda_oe = ~rd_data[7];
              nxt_ptr = ptr_ff + 8'h1;
              rd_clr = (ptr_ff == OFS_STATUS);
            end
          end
        end
        SER_TX: begin
          if (scl_rise) begin
            nxt_bits = bits_ff + 4'h1;
          end else if (scl_fall && bits_ff == 4'h8) begin
            nxt_bits = 4'h0;
            nxt_sda_oe = 1'b0;
            nxt_ser = SER_TX_ACK;
          end else if (scl_fall) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_sda_oe = ~shift_ff[6];
          end
        end
        SER_TX_ACK: begin
          if (scl_rise) begin
            nxt_ack_ok = ~i_sda;
          end else if (scl_fall) begin
            nxt_ser = ack_ok_ff ? SER_TX : SER_IDLE;
            if (ack_ok_ff) begin
              nxt_shift = rd_data;
              nxt_sda_oe = ~rd_data[7];
              nxt_ptr = ptr_ff + 8'h1;
              rd_clr = (ptr_ff == OFS_STATUS);
            end
          end
        end
        default: nxt_ser = SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ser_ff <= SER_IDLE;
      ret_ff <= SER_IDLE;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      bits_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      ser_ff <= nxt_ser;
      ret_ff <= nxt_ret;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      bits_ff <= nxt_bits;
      sda_oe_ff <= nxt_sda_oe;
      ack_ok_ff <= nxt_ack_ok;
      scl_q_ff <= i_scl;
      sda_q_ff <= i_sda;
    end
  end

  // Open-drain data line only ever pulls low
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe_ff;

  // Address strap caught once, on the first edge after reset release
  always_comb begin
    nxt_addr_lsb = strap_done_ff ? addr_lsb_ff : i_irq_pin;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_lsb_ff <= 1'b0;
      strap_done_ff <= 1'b0;
    end else begin
      addr_lsb_ff <= nxt_addr_lsb;
      strap_done_ff <= 1'b1;
    end
  end

  // Register writes; the whole byte is stored, banned codes included
  always_comb begin
    nxt_slot_ctrl = slot_ctrl_ff;
    nxt_dbc[0] = dbc_ff[0];
    nxt_dbc[1] = dbc_ff[1];
    nxt_clk_src = clk_src_ff;
    restart = 2'b00;
    if (wr_stb) begin
      case (ptr_ff)
        OFS_SLOT_CTRL: nxt_slot_ctrl = wr_data;
        OFS_SDN_DBC: begin
          nxt_dbc[0] = wr_data;
          restart[0] = 1'b1;
        end
        OFS_BAT_DBC: begin
          nxt_dbc[1] = wr_data;
          restart[1] = 1'b1;
        end
        OFS_CLK_SRC: nxt_clk_src = wr_data;
        default: nxt_slot_ctrl = slot_ctrl_ff;
      endcase
    end
  end

  // Event flags: a read clears, but a shutdown expiry or a rising battery expiry in the same cycle wins
  always_comb begin
    nxt_sdn_flag = (sdn_flag_ff & ~rd_clr) | expire[0];
    nxt_bat_flag = (bat_flag_ff & ~rd_clr) | (expire[1] & din[1]);
    nxt_sdn_level = expire[0] ? din[0] : sdn_level_ff;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slot_ctrl_ff <= RST_SLOT_CTRL;
      dbc_ff[0] <= RST_DBC;
      dbc_ff[1] <= RST_DBC;
      clk_src_ff <= RST_CLK_SRC;
      sdn_flag_ff <= 1'b0;
      bat_flag_ff <= 1'b0;
      sdn_level_ff <= 1'b0;
    end else begin
      slot_ctrl_ff <= nxt_slot_ctrl;
      dbc_ff[0] <= nxt_dbc[0];
      dbc_ff[1] <= nxt_dbc[1];
      clk_src_ff <= nxt_clk_src;
      sdn_flag_ff <= nxt_sdn_flag;
      bat_flag_ff <= nxt_bat_flag;
      sdn_level_ff <= nxt_sdn_level;
    end
  end

  // Timing tick: internal divider or sampled rising edge of external clock
  always_comb begin
    nxt_div = (div_ff == TICK_DIV - 10'h1) ? 10'h000 : div_ff + 10'h1;
    tick = clk_src_ff[CLK_SRC_BIT] ? (i_ext_timing_clk & ~ext_q_ff)
                                   : (div_ff == 10'h000);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_ff <= 10'h000;
      ext_q_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      ext_q_ff <= i_ext_timing_clk;
    end
  end

  // Debouncers: channel 0 shutdown, channel 1 battery presence
  assign din = {i_battery_presence_input, i_shutdown_input};
  for (genvar ch = 0; ch < 2; ch++) begin : g_dbc
    // Counting in ticks lets a fresh reload act by the next tick
    always_comb begin
      nxt_level[ch] = level_ff[ch];
      nxt_cnt[ch] = cnt_ff[ch];
      expire[ch] = 1'b0;
      if (din[ch] == level_ff[ch] || restart[ch]) begin
        nxt_cnt[ch] = 8'h00;
      end else if (dbc_ff[ch] == 8'h00) begin
        nxt_level[ch] = din[ch];
        expire[ch] = 1'b1;
      end else if (tick) begin
        if (cnt_ff[ch] + 8'h1 >= dbc_ff[ch]) begin
          nxt_level[ch] = din[ch];
          nxt_cnt[ch] = 8'h00;
          expire[ch] = 1'b1;
        end else begin
          nxt_cnt[ch] = cnt_ff[ch] + 8'h1;
        end
      end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        level_ff[ch] <= 1'b0;
        cnt_ff[ch] <= 8'h00;
      end else begin
        level_ff[ch] <= nxt_level[ch];
        cnt_ff[ch] <= nxt_cnt[ch];
      end
    end
  end

  // Slot drive outputs, registered so each port leaves a flip-flop
  always_comb begin
    nxt_one.supply_on = slot_ctrl_ff[SLOT1_REG_EN];
    nxt_one.supply_pulldown = ~slot_ctrl_ff[SLOT1_REG_EN];
    nxt_one.volt_high = slot_ctrl_ff[SLOT1_VSEL];
    nxt_one.status = status_byte[ST_SLOT1_LO +: 2];
    nxt_one.iface_pulldown = ~nxt_one.status[0];
    nxt_one.iface_active = (nxt_one.status == CODE_ACTIVE);
    nxt_two.supply_on = slot_ctrl_ff[SLOT2_REG_EN];
    nxt_two.supply_pulldown = ~slot_ctrl_ff[SLOT2_REG_EN];
    nxt_two.volt_high = slot_ctrl_ff[SLOT2_VSEL];
    nxt_two.status = status_byte[ST_SLOT2_LO +: 2];
    nxt_two.iface_pulldown = ~nxt_two.status[0];
    nxt_two.iface_active = (nxt_two.status == CODE_ACTIVE);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_slot_one_supply <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, CODE_DOWN};
      o_slot_two_supply <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, CODE_DOWN};
    end else begin
      o_slot_one_supply <= nxt_one;
      o_slot_two_supply <= nxt_two;
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_dbc_write;
    wr_stb && ptr_ff == OFS_SDN_DBC;
  endsequence
  a_slot_off_status: assert property (
    !slot_ctrl_ff[SLOT1_REG_EN] |-> status_byte[5:4] == CODE_DOWN)
    else $error("slot one off but status not 00");
  a_isolated_status: assert property (
    status_byte[7:6] == CODE_ISOL |->
      slot_ctrl_ff[7:6] == CODE_ISOL && slot_ctrl_ff[SLOT2_REG_EN])
    else $error("slot two isolated without cause");
  a_active_status: assert property (
    status_byte[5:4] == CODE_ACTIVE |->
      slot_ctrl_ff[3:2] == CODE_ACTIVE && slot_ctrl_ff[SLOT1_REG_EN])
    else $error("slot one active without cause");
  a_powered_pd: assert property (
    slot_ctrl_ff[SLOT1_REG_EN] && !slot_ctrl_ff[SLOT1_STATE_LO]
      |-> status_byte[5:4] == CODE_PWR_PD)
    else $error("slot one powered code wrong");
  a_supply_follow: assert property (
    ##1 o_slot_two_supply.supply_on == $past(slot_ctrl_ff[SLOT2_REG_EN])
      && o_slot_two_supply.supply_pulldown != o_slot_two_supply.supply_on)
    else $error("slot two supply does not follow control");
  a_volt_follow: assert property (
    ##1 o_slot_one_supply.volt_high == $past(slot_ctrl_ff[SLOT1_VSEL]))
    else $error("slot one voltage does not follow select");
  a_dbc_bypass: assert property (
    dbc_ff[1] == 8'h00 && !restart[1] && din[1] != level_ff[1]
      |=> level_ff[1] == $past(din[1]))
    else $error("battery bypass did not pass level");
  a_dbc_restart: assert property (
    s_dbc_write |=> cnt_ff[0] == 8'h00 && dbc_ff[0] == $past(wr_data))
    else $error("shutdown counter not restarted on write");
  a_sdn_capture: assert property (
    expire[0] |=> sdn_flag_ff && sdn_level_ff == $past(din[0]))
    else $error("shutdown level not captured with flag");
endmodule
`default_nettype wire

// *** simsc_host.sv ***
// Serial bus host model driving the register bank's target port
`timescale 1ns/1ps
`default_nettype none
module simsc_host (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // Bus idle: clock high, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Four system clocks per level keeps each level over two target samples
  task automatic half();
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  // Data changes only while the bus clock is low
  task automatic put_bit(input logic b);
    o_sda_oe = ~b;
    half();
    o_scl = 1'b1;
    half();
    o_scl = 1'b0;
  endtask
  // Line released, so a high reads back unless the target pulls low
  task automatic get_bit(output logic b);
    o_sda_oe = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    b = i_sda;
    o_scl = 1'b0;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    o_sda_oe = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_oe = 1'b1;
    half();
    o_scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    o_sda_oe = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_oe = 1'b0;
    half();
  endtask
  // Byte out MSB first, then the target's acknowledge bit
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask
  // Bytes go out as given, a banned state code too
  task automatic wr(input logic [6:0] adr, input logic [7:0] ofs,
                    input logic [7:0] d, output logic ack);
    logic a2;
    start();
    put_byte({adr, 1'b0}, ack);
    put_byte(ofs, a2);
    put_byte(d, a2);
    stop();
  endtask
  // Pointer write, repeated start, one byte read ended by a NACK
  task automatic rd(input logic [6:0] adr, input logic [7:0] ofs,
                    output logic [7:0] d);
    logic a2;
    logic b;
    start();
    put_byte({adr, 1'b0}, a2);
    put_byte(ofs, a2);
    start();
    put_byte({adr, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(1'b1);
    stop();
  endtask
endmodule
`default_nettype wire

// *** sim_slot_ctrl_debounce_regs_tb_top.sv ***
// Self-checking bench for the card slot control register bank
`timescale 1ns/1ps
`default_nettype none
module sim_slot_ctrl_debounce_regs_tb_top
  import simsc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic irq = 1'b0;
  logic ext_clk = 1'b0;
  logic sdn_in = 1'b0;
  logic bat_in = 1'b0;
  logic scl;
  logic host_oe;
  logic dut_oe;
  logic dut_sda;
  logic [6:0] adr = {TGT_ADDR_HI, 1'b0};
  wire logic sda_w;
  simsc_slot_t slot1;
  simsc_slot_t slot2;
  int failures = 0;
  int comparisons = 0;
  // Open-drain data line with pull-up; the target shows its drive value
  assign sda_w = ~host_oe & (dut_oe ? dut_sda : 1'b1);
  always #25 clk = ~clk;
  simsc_regs DUT (
    .i_ref_clk(clk),
    .i_rst_b(rst_b),
    .i_scl(scl),
    .i_sda(sda_w),
    .o_sda(dut_sda),
    .o_sda_oe(dut_oe),
    .i_irq_pin(irq),
    .i_ext_timing_clk(ext_clk),
    .i_shutdown_input(sdn_in),
    .i_battery_presence_input(bat_in),
    .o_slot_one_supply(slot1),
    .o_slot_two_supply(slot2)
  );
  simsc_host host (
    .i_ref_clk(clk),
    .i_sda(sda_w),
    .o_scl(scl),
    .o_sda_oe(host_oe)
  );
  // Expected status code of one slot from its state and regulator bits
  function automatic logic [1:0] exp_code(logic [1:0] st, logic on);
    if (!on) return CODE_DOWN;
    if (st == CODE_ISOL || st == CODE_ACTIVE) return st;
    return CODE_PWR_PD;
  endfunction
  function automatic simsc_slot_t exp_slot(logic on, logic vs,
                                           logic [1:0] st);
    simsc_slot_t s;
    s.status = exp_code(st, on);
    s.supply_on = on;
    s.supply_pulldown = ~on;
    s.volt_high = vs;
    s.iface_pulldown = ~s.status[0];
    s.iface_active = (s.status == CODE_ACTIVE);
    return s;
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_slot(input simsc_slot_t got, input simsc_slot_t exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ack;
    host.wr(adr, ofs, d, ack);
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    host.rd(adr, ofs, d);
  endtask
  // External timing clock pulse; held long enough for the sampler
  task automatic tick();
    ext_clk = 1'b1;
    repeat (8) @(posedge clk);
    #1 ext_clk = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic set_in(input int c, input logic v);
    if (c == 1) bat_in = v;
    else sdn_in = v;
  endtask
  // Write slot control, then check readback, slot drives and status codes
  task automatic check_ctrl(input logic [7:0] v);
    logic [7:0] got;
    logic [7:0] want;
    wr(OFS_SLOT_CTRL, v);
    rd(OFS_SLOT_CTRL, got);
    check8(got, v);
    check_slot(slot1, exp_slot(v[0], v[1], v[3:2]));
    check_slot(slot2, exp_slot(v[4], v[5], v[7:6]));
    rd(OFS_STATUS, got);
    want = {exp_code(v[7:6], v[4]), exp_code(v[3:2], v[0]), 4'h0};
    check8(got & 8'hf0, want);
  endtask
  // Watchdog: the whole sequence needs roughly 25000 clocks
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    logic [7:0] got;
    logic [7:0] v;
    logic [7:0] dofs;
    logic ack;
    int lb;
    logic [7:0] rofs [5];
    logic [7:0] rexp [5];
    void'($urandom(32'h2570));
    rofs = '{OFS_SLOT_CTRL, OFS_BAT_DBC, OFS_SDN_DBC, OFS_CLK_SRC, 8'h0c};
    rexp = '{RST_SLOT_CTRL, RST_DBC, RST_DBC, RST_CLK_SRC, 8'h00};
    repeat (20) @(posedge clk);
    #1 check_slot(slot1, exp_slot(1'b0, 1'b0, 2'h0));
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    foreach (rofs[i]) begin
      rd(rofs[i], got);
      check8(got, rexp[i]);
    end
    // Every state and regulator pairing on both slots, then random bytes
    for (int i = 0; i < 8; i++) begin
      check_ctrl({i[2:1], 1'b1, i[0], i[2:1], 1'b0, ~i[0]});
    end
    repeat (8) check_ctrl(8'($urandom));
    // External source so debounce ticks come only from the bench
    v = {1'b1, 7'($urandom)};
    wr(OFS_CLK_SRC, v);
    rd(OFS_CLK_SRC, got);
    check8(got, v);
    for (int c = 0; c < 2; c++) begin
      dofs = (c == 1) ? OFS_BAT_DBC : OFS_SDN_DBC;
      lb = (c == 1) ? ST_BAT_LEVEL : ST_SDN_LEVEL;
      wr(dofs, 8'h03);
      set_in(c, 1'b1);
      repeat (2) tick();
      rd(OFS_STATUS, got);
      check8({6'h0, got[lb+:2]}, 8'h00);
      tick();
      rd(OFS_STATUS, got);
      check8({6'h0, got[lb+:2]}, 8'h03);
      rd(OFS_STATUS, got);
      check8({6'h0, got[lb+:2]}, 8'h01);
      // Rewrite mid-count must restart from the new, shorter reload
      set_in(c, 1'b0);
      repeat (2) tick();
      wr(dofs, 8'h02);
      tick();
      rd(OFS_STATUS, got);
      check8({6'h0, got[lb+:2]}, 8'h01);
      tick();
      rd(OFS_STATUS, got);
      check8({6'h0, got[lb+:2]}, (c == 1) ? 8'h00 : 8'h02);
      // Zero reload: the level passes straight through
      wr(dofs, 8'h00);
      set_in(c, 1'b1);
      rd(OFS_STATUS, got);
      check8({6'h0, got[lb+:2]}, 8'h03);
    end
    // Second reset with the interrupt pin high moves the target address
    irq = 1'b1;
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    host.wr({TGT_ADDR_HI, 1'b0}, OFS_SLOT_CTRL, 8'h11, ack);
    check8({7'h0, ack}, 8'h00);
    adr = {TGT_ADDR_HI, 1'b1};
    rd(OFS_SLOT_CTRL, got);
    check8(got, RST_SLOT_CTRL);
    rd(OFS_SDN_DBC, got);
    check8(got, RST_DBC);
    check_ctrl(8'h11);
    // Both inputs held high since reset: internal ticks must expire both
    repeat (600) @(posedge clk);
    #1;
    rd(OFS_STATUS, got);
    check8(got & 8'h0f, 8'h0f);
    test_done();
  end
endmodule
`default_nettype wire
